// ---- core/high_port_gpio_bank.v ----
// gpio logic for four byte-wide high ports with memory-interface override
`timescale 1ns/10ps
`default_nettype none
`include "high_port_regs.vh"

module high_port_gpio_bank #(
  parameter NPORTS = 4,
  parameter WIDTH = 8
) (
  // clock and reset
  input wire mclk,
  input wire resetn,
  // special function register access
  input wire [7:0] reg_page,
  input wire [7:0] reg_addr,
  input wire reg_byte_wr,
  input wire reg_bit_wr,
  input wire reg_bit_val,
  input wire [7:0] reg_wdata,
  input wire reg_rd,
  input wire reg_rmw,
  output reg [7:0] reg_rdata_ff,
  // crossbar global control
  input wire pullup_global_disable,
  input wire memif_low_port_enable,
  // external memory interface
  input wire memif_high_enable,
  input wire memif_active,
  input wire memif_read,
  input wire memif_muxed,
  input wire memif_wr_n,
  input wire memif_rd_n,
  input wire memif_ale,
  input wire [15:0] memif_addr,
  input wire [7:0] memif_wdata,
  // pins, ports four to seven packed low to high
  input wire [NPORTS*WIDTH-1:0] pin_in,
  output reg [NPORTS*WIDTH-1:0] pin_out_ff,
  output reg [NPORTS*WIDTH-1:0] pin_oe_ff,
  output reg [NPORTS*WIDTH-1:0] pullup_en_ff
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  // port index codes; idx_none marks an address outside the bank
  localparam [2:0] IDX_FOUR = 3'h0;
  localparam [2:0] IDX_FIVE = 3'h1;
  localparam [2:0] IDX_SIX = 3'h2;
  localparam [2:0] IDX_SEVEN = 3'h3;
  localparam [2:0] IDX_NONE = 3'h4;

  // returns the port index for a latch address, or IDX_NONE when none
  function [2:0] latch_index;
    input [7:0] a;
    begin
      case (a)
        `PORT_FOUR_DATA_LATCH_ADDR: latch_index = IDX_FOUR;
        `PORT_FIVE_DATA_LATCH_ADDR: latch_index = IDX_FIVE;
        `PORT_SIX_DATA_LATCH_ADDR: latch_index = IDX_SIX;
        `PORT_SEVEN_DATA_LATCH_ADDR: latch_index = IDX_SEVEN;
        default: latch_index = IDX_NONE;
      endcase
    end
  endfunction

  function [2:0] mode_index;
    input [7:0] a;
    begin
      case (a)
        `PORT_FOUR_OUTPUT_MODE_ADDR: mode_index = IDX_FOUR;
        `PORT_FIVE_OUTPUT_MODE_ADDR: mode_index = IDX_FIVE;
        `PORT_SIX_OUTPUT_MODE_ADDR: mode_index = IDX_SIX;
        `PORT_SEVEN_OUTPUT_MODE_ADDR: mode_index = IDX_SEVEN;
        default: mode_index = IDX_NONE;
      endcase
    end
  endfunction

  // bit writes address the latch byte by the upper five address bits
  function [2:0] bit_latch_index;
    input [7:0] a;
    begin
      bit_latch_index = latch_index({a[`BIT_SEL_HI:`BIT_SEL_LO], 3'h0});
    end
  endfunction

  wire page_ok = (reg_page == `PORT_PAGE);
  wire [2:0] lidx = latch_index(reg_addr);
  wire [2:0] midx = mode_index(reg_addr);
  wire [2:0] bidx = bit_latch_index(reg_addr);
  wire [2:0] bpos = reg_addr[`BIT_POS_HI:`BIT_POS_LO];

  reg [NPORTS*WIDTH-1:0] latch_ff;
  reg [NPORTS*WIDTH-1:0] mode_ff;

  ////////////////////////////////////////////////////////////////////////////
  // memory interface override map
  // ovr_en: pin taken by the memory interface; ovr_val: level it wants
  reg [NPORTS*WIDTH-1:0] ovr_en;
  reg [NPORTS*WIDTH-1:0] ovr_val;
  reg [NPORTS*WIDTH-1:0] ovr_float;
  wire memif_on = memif_high_enable & memif_active;
  always @*
  begin
    ovr_en = {NPORTS*WIDTH{1'b0}};
    ovr_val = {NPORTS*WIDTH{1'b0}};
    ovr_float = {NPORTS*WIDTH{1'b0}};
    if (memif_on)
    begin
      ovr_en[`WR_STROBE_BIT] = 1'b1;
      ovr_val[`WR_STROBE_BIT] = memif_wr_n;
      ovr_en[`RD_STROBE_BIT] = 1'b1;
      ovr_val[`RD_STROBE_BIT] = memif_rd_n;
      ovr_en[`ALE_STROBE_BIT] = 1'b1;
      ovr_val[`ALE_STROBE_BIT] = memif_ale;
      if (!memif_muxed)
      begin
        ovr_en[2*WIDTH-1:WIDTH] = {WIDTH{1'b1}};
        ovr_val[2*WIDTH-1:WIDTH] = memif_addr[15:8];
        ovr_en[3*WIDTH-1:2*WIDTH] = {WIDTH{1'b1}};
        ovr_val[3*WIDTH-1:2*WIDTH] = memif_addr[7:0];
        ovr_val[4*WIDTH-1:3*WIDTH] = memif_wdata;
      end
      else
      begin
        ovr_en[3*WIDTH-1:2*WIDTH] = {WIDTH{1'b1}};
        ovr_val[3*WIDTH-1:2*WIDTH] = memif_addr[15:8];
        // address phase while ale is high, data afterwards
        ovr_val[4*WIDTH-1:3*WIDTH] = memif_ale ? memif_addr[7:0] : memif_wdata;
      end
      ovr_en[4*WIDTH-1:3*WIDTH] = {WIDTH{1'b1}};
      // data bus released on reads, except while muxed address is out
      if (memif_read && !(memif_muxed && memif_ale))
        ovr_float[4*WIDTH-1:3*WIDTH] = {WIDTH{1'b1}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // latches and mode registers
  reg [NPORTS*WIDTH-1:0] nxt_latch;
  reg [NPORTS*WIDTH-1:0] nxt_mode;
  always @*
  begin
    nxt_latch = latch_ff;
    nxt_mode = mode_ff;
    if (page_ok && reg_byte_wr && lidx < NPORTS)
      nxt_latch[lidx*WIDTH +: WIDTH] = reg_wdata;
    if (page_ok && reg_bit_wr && bidx < NPORTS)
      nxt_latch[bidx*WIDTH + bpos] = reg_bit_val;
    if (page_ok && reg_byte_wr && midx < NPORTS)
      nxt_mode[midx*WIDTH +: WIDTH] = reg_wdata;
  end

  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      latch_ff <= {NPORTS{`LATCH_RESET}};
      mode_ff <= {NPORTS{`MODE_RESET}};
    end
    else
    begin
      latch_ff <= nxt_latch;
      mode_ff <= nxt_mode; // modes never touched by memory traffic
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers and pullups
  // pins are registered from the next latch value, so a write shows on the pin at the same clock as in the latch
  // per-bit continuous assigns keep each vector to a single driver
  wire [NPORTS*WIDTH-1:0] nxt_out;
  wire [NPORTS*WIDTH-1:0] nxt_oe;
  wire [NPORTS*WIDTH-1:0] nxt_pu;
  wire [NPORTS*WIDTH-1:0] nxt_drv_low;
  genvar g;
  generate
    for (g = 0; g < NPORTS*WIDTH; g = g + 1)
    begin : pin_drv
      // memory interface wins over the latch while it owns the pin
      assign nxt_out[g] = ovr_en[g] ? ovr_val[g] : nxt_latch[g];
      // zero drives unless the data bus is released for a read; one drives only in push-pull
      assign nxt_oe[g] = ~ovr_float[g] & (~nxt_out[g] | nxt_mode[g]);
      // pin pulling itself low must not fight its own pullup
      assign nxt_drv_low[g] = nxt_oe[g] & ~nxt_out[g];
      assign nxt_pu[g] = ~pullup_global_disable & ~nxt_drv_low[g];
    end
  endgenerate

  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      pin_out_ff <= {NPORTS{`LATCH_RESET}};
      pin_oe_ff <= {NPORTS*WIDTH{1'b0}};
      pullup_en_ff <= {NPORTS*WIDTH{1'b1}};
    end
    else
    begin
      pin_out_ff <= nxt_out;
      pin_oe_ff <= nxt_oe;
      pullup_en_ff <= nxt_pu;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path
  reg [7:0] nxt_rdata;
  always @*
  begin
    nxt_rdata = reg_rdata_ff;
    if (reg_rd)
    begin
      nxt_rdata = 8'h00;
      if (page_ok && lidx < NPORTS)
        nxt_rdata = reg_rmw ? latch_ff[lidx*WIDTH +: WIDTH]
                            : pin_in[lidx*WIDTH +: WIDTH];
      else if (page_ok && midx < NPORTS)
        nxt_rdata = mode_ff[midx*WIDTH +: WIDTH];
    end
  end

  always @(posedge mclk)
  begin
    if (!resetn)
      reg_rdata_ff <= 8'h00;
    else
      reg_rdata_ff <= nxt_rdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // usage notes
  // pins are registered from the next latch value: a write shows on the pin at the same clock that takes it
  // a read right after a write may still see the old pin level,
  // since pin_in comes back through the outside load
  // read data stands in reg_rdata_ff until the next read strobe
  // off-page or unmapped reads give zero, so stale data never leaks
  // off-page writes are dropped without any flag
  // bit writes reach only the data latches;
  // a bit address on a mode register decodes to nothing
  // byte and bit write in one cycle: the bit write wins on its bit,
  // the byte write keeps the other seven bits
  // mode registers are byte-only and never touched by memory traffic
  // read-modify-write strobe is a level that qualifies reg_rd;
  // without reg_rd it has no effect
  // memory override is purely combinational into the pin registers,
  // so the pins follow the interface one clock late
  // overridden pins still obey their mode bits:
  // an open-drain strobe pin only pulls low, its own pullup or the load pulls it up
  // data bus release on reads covers the whole read cycle,
  // except the address phase of multiplexed mode
  // memif_low_port_enable is accepted but not decoded here;
  // keeping it low is left to software
  // pullup disable acts on all 32 pins at once,
  // there is no per-pin pullup control
  // pullups of pins that drive low switch off even when globally enabled
  // reset: latches all ones, modes open-drain, so every pin floats high
  // on its pullup until software configures it
  // the port index codes above are shared by byte and bit decode,
  // which is why decode sits in functions
  // widening the bank means new addresses in the header and new
  // decode entries; the pin logic scales with NPORTS
  // trade-off: pins are registered for clean outputs at the cost
  // of one clock of latency on memory interface and pullup disable changes; register writes reach the pin at the same clock as the latch

endmodule // high_port_gpio_bank
`default_nettype wire

// ---- core/high_port_regs.vh ----
// register offsets, reset values and field positions of the high-port gpio bank
`ifndef HIGH_PORT_REGS_VH
`define HIGH_PORT_REGS_VH

`define PORT_FOUR_OUTPUT_MODE_ADDR 8'h9c
`define PORT_FIVE_OUTPUT_MODE_ADDR 8'h9d
`define PORT_SIX_OUTPUT_MODE_ADDR 8'h9e
`define PORT_SEVEN_OUTPUT_MODE_ADDR 8'h9f
`define PORT_FOUR_DATA_LATCH_ADDR 8'hc8
`define PORT_FIVE_DATA_LATCH_ADDR 8'hd8
`define PORT_SIX_DATA_LATCH_ADDR 8'he8
`define PORT_SEVEN_DATA_LATCH_ADDR 8'hf8
`define PORT_PAGE 8'h0f
`define LATCH_RESET 8'hff
`define MODE_RESET 8'h00
`define WR_STROBE_BIT 7
`define RD_STROBE_BIT 6
`define ALE_STROBE_BIT 5
`define BIT_SEL_HI 7
`define BIT_SEL_LO 3
`define BIT_POS_HI 2
`define BIT_POS_LO 0

`endif

// ---- verification/high_port_gpio_bank_asserts.sv ----
// port-level assertions for the high-port gpio bank
`timescale 1ns/10ps
`default_nettype none
module gpio_bank_asserts (
  input wire logic mclk, resetn, reg_byte_wr, reg_bit_wr, reg_rd, reg_rmw, pullup_global_disable,
  input wire logic memif_high_enable, memif_active, memif_read, memif_muxed, memif_ale, memif_wr_n, memif_rd_n,
  input wire logic [7:0] reg_page, reg_addr, reg_wdata, reg_rdata_ff,
  input wire logic [31:0] pin_in, pin_out_ff, pin_oe_ff, pullup_en_ff
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  wire logic pg = reg_page == 8'h0f;
  wire logic mon = memif_active & memif_high_enable;
  a_pullup_off: assert property (pullup_global_disable [*2] |-> pullup_en_ff == 0) else $error("pullup on");
  a_low_no_pull: assert property ((pin_oe_ff & ~pin_out_ff & pullup_en_ff) == 0) else $error("pullup vs low");
  a_byte_write: assert property (pg && reg_byte_wr && !reg_bit_wr && reg_addr == 8'hc8 && !mon
    |=> pin_out_ff[7:0] == $past(reg_wdata)) else $error("latch write");
  a_pin_read: assert property (pg && reg_rd && !reg_rmw && reg_addr == 8'hd8
    |=> reg_rdata_ff == $past(pin_in[15:8])) else $error("pin read");
  a_rmw_read: assert property (pg && reg_rd && reg_rmw && reg_addr == 8'he8 && !$past(mon)
    |=> reg_rdata_ff == $past(pin_out_ff[23:16])) else $error("rmw read");
  a_page_refuse: assert property (reg_rd && !pg |=> reg_rdata_ff == 8'h00) else $error("off-page read");
  a_strobes: assert property (mon |=> pin_out_ff[7] == $past(memif_wr_n) && pin_out_ff[6] == $past(memif_rd_n))
    else $error("strobes");
  a_data_float: assert property (mon && memif_read && !(memif_muxed && memif_ale)
    |=> pin_oe_ff[31:24] == 8'h00) else $error("data driven");
  c_rmw: cover property (pg && reg_rd && reg_rmw);
  c_bit: cover property (pg && reg_bit_wr);
  c_mem_read: cover property (mon && memif_read);
endmodule // gpio_bank_asserts
bind high_port_gpio_bank gpio_bank_asserts chk (.mclk, .resetn, .reg_byte_wr, .reg_bit_wr, .reg_rd, .reg_rmw,
  .pullup_global_disable, .memif_high_enable, .memif_active, .memif_read, .memif_muxed, .memif_ale, .memif_wr_n,
  .memif_rd_n, .reg_page, .reg_addr, .reg_wdata, .reg_rdata_ff, .pin_in, .pin_out_ff, .pin_oe_ff, .pullup_en_ff);
`default_nettype wire

// ---- verification/pin_load_model.sv ----
// external load on the high-port pins
`timescale 1ns/10ps
`default_nettype none
module pin_load_model (
  input wire logic mclk,
  input wire logic [31:0] pin_out, pin_oe, pullup_en, ext_drv, ext_val,
  output logic [31:0] pin_in
);
  logic [31:0] flt_ff = 32'h5555_5555;
  // unpulled open lines wander, so no stale level reads back
  always @(posedge mclk) flt_ff <= ~flt_ff;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drv & ext_val) | (~pin_oe & ~ext_drv & (pullup_en | flt_ff));
endmodule // pin_load_model
`default_nettype wire

// ---- verification/high_port_gpio_bank_tb.sv ----
// self-checking bench for the high-port gpio bank
`timescale 1ns/10ps
`default_nettype none
module high_port_gpio_bank_tb;
  logic mclk = 0, resetn = 0, reg_byte_wr = 0, reg_bit_wr = 0, reg_bit_val = 0, reg_rd = 0, reg_rmw = 0;
  logic pullup_global_disable = 0, memif_low_port_enable = 0, memif_high_enable = 0, memif_active = 0;
  logic memif_read = 0, memif_muxed = 0, memif_wr_n = 1, memif_rd_n = 1, memif_ale = 0;
  logic [7:0] reg_page = 8'h0f, reg_addr = 0, reg_wdata = 0, reg_rdata_ff, memif_wdata = 0, d, m, e, o, rb;
  logic [15:0] memif_addr = 0;
  logic [31:0] pin_in, pin_out_ff, pin_oe_ff, pullup_en_ff, ext_drv = 0, ext_val = 0;
  integer failures = 0, num_checks = 0, cyc = 0, seed = 32'h09bc, i, b;
  high_port_gpio_bank uut (.mclk, .resetn, .reg_page, .reg_addr, .reg_byte_wr, .reg_bit_wr, .reg_bit_val,
    .reg_wdata, .reg_rd, .reg_rmw, .reg_rdata_ff, .pullup_global_disable, .memif_low_port_enable,
    .memif_high_enable, .memif_active, .memif_read, .memif_muxed, .memif_wr_n, .memif_rd_n, .memif_ale,
    .memif_addr, .memif_wdata, .pin_in, .pin_out_ff, .pin_oe_ff, .pullup_en_ff);
  pin_load_model load (.mclk, .pin_out(pin_out_ff), .pin_oe(pin_oe_ff), .pullup_en(pullup_en_ff), .ext_drv,
    .ext_val, .pin_in);
  initial forever #20 mclk = ~mclk;
  always @(posedge mclk) if (++cyc == 3000) begin failures++; close_out; end
  ////////////////////////////////////////////////////////////////////////
  task tick; @(posedge mclk); #1; endtask
  task chk(input string nm, input logic [31:0] ex, got);
    num_checks++;
    if (got !== ex) begin failures++; $display("wrong value %s exp %h got %h", nm, ex, got); end
  endtask
  // strobes drop for a cycle so no signal is set twice in one step
  task wr(input logic [7:0] a, dt); reg_addr = a; reg_wdata = dt; reg_byte_wr = 1; tick; reg_byte_wr = 0; tick; endtask
  task rd(input logic [7:0] a, input logic rmw);
    reg_addr = a; reg_rd = 1; reg_rmw = rmw; tick; reg_rd = 0; reg_rmw = 0; tick; rb = reg_rdata_ff;
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) tick;
    resetn = 1;
    chk("latch reset", 32'hffffffff, pin_out_ff);
    chk("oe reset", 0, pin_oe_ff);
    chk("pullup reset", 32'hffffffff, pullup_en_ff);
    $display("reset test done");
    for (i = 0; i < 4; i++)
    begin
      rd(8'h9c + i, 0); chk("mode reset", 0, rb);
      d = $random(seed); m = $random(seed); e = $random(seed);
      if (i == 0) d = 8'h00;
      o = m | ~d;
      wr(8'h9c + i, m); wr(8'hc8 + 16 * i, d);
      ext_drv[8*i +: 8] = ~o; ext_val[8*i +: 8] = e;
      chk("pin out", d, pin_out_ff[8*i +: 8]);
      chk("pin oe", o, pin_oe_ff[8*i +: 8]);
      chk("pullup", d, pullup_en_ff[8*i +: 8]);
      rd(8'hc8 + 16 * i, 1); chk("rmw read", d, rb);
      rd(8'hc8 + 16 * i, 0); chk("pin read", (m & d) | (~m & d & e), rb);
      b = $random(seed) & 7;
      reg_addr = 8'hc8 + 16 * i + b; reg_bit_val = ~d[b]; reg_bit_wr = 1; tick; reg_bit_wr = 0; tick;
      d[b] = ~d[b];
      chk("bit write", d, pin_out_ff[8*i +: 8]);
      reg_page = 8'h00; wr(8'hc8 + 16 * i, ~d); rd(8'hc8 + 16 * i, 0); reg_page = 8'h0f;
      chk("off page read", 0, rb);
      chk("off page write", d, pin_out_ff[8*i +: 8]);
      $display("port %0d test done", i);
    end
    pullup_global_disable = 1; tick; tick;
    chk("pullup off", 0, pullup_en_ff);
    pullup_global_disable = 0;
    // low-port memory enable stays at zero while memory uses high ports
    memif_high_enable = 1; memif_active = 1; memif_addr = $random(seed); memif_wdata = $random(seed);
    memif_ale = 1; memif_read = 1; memif_rd_n = 0; tick; tick;
    chk("strobes", {memif_wr_n, memif_rd_n, memif_ale}, pin_out_ff[7:5]);
    chk("addr high", memif_addr[15:8], pin_out_ff[15:8]);
    chk("addr low", memif_addr[7:0], pin_out_ff[23:16]);
    chk("data float", 0, pin_oe_ff[31:24]);
    memif_muxed = 1; memif_read = 0; memif_rd_n = 1; memif_wr_n = 0; memif_ale = 0; tick; tick;
    chk("muxed addr", memif_addr[15:8], pin_out_ff[23:16]);
    chk("muxed data", memif_wdata, pin_out_ff[31:24]);
    memif_active = 0; memif_wr_n = 1; tick; tick;
    rd(8'h9f, 0); chk("mode kept", m, rb);
    chk("latch back", d, pin_out_ff[31:24]);
    $display("memif test done");
    close_out;
  end
endmodule // high_port_gpio_bank_tb
`default_nettype wire
